// ==== hart_consts.vh ====
// Constants shared by the HART master frame engine and its character unit
`ifndef HART_CONSTS_VH
`define HART_CONSTS_VH

// Timing
`define CLK_HZ 20000000
`define HART_BAUD 1200
// Clock over baud rate, rounded up, sized to the bit counter
`define HART_BIT_CYCLES 15'h411B
`define RSP_TIMEOUT_MS 500
// Response limit in clock cycles, sized to the timer
`define RSP_TIMEOUT_CYCLES 24'h989680

// Character format: start, 8 data, odd parity, stop
`define CHAR_BITS 11

// Frame bytes
`define PREAMBLE_BYTE 8'hFF
`define PREAMBLE_MIN 5'h05
`define PREAMBLE_MAX 5'h14
`define DELIM_SHORT_BURST 8'h01
`define DELIM_SHORT_M2S 8'h02
`define DELIM_SHORT_S2M 8'h06
`define DELIM_LONG_BURST 8'h81
`define DELIM_LONG_M2S 8'h82
`define DELIM_LONG_S2M 8'h86
`define HDR_LEN_SHORT 4'h4
`define HDR_LEN_LONG 4'h8
`define RHDR_LEN_SHORT 4'h3
`define RHDR_LEN_LONG 4'h7

// Completion codes
`define ERR_NONE 3'h0
`define ERR_TIMEOUT 3'h1
`define ERR_DELIM 3'h2
`define ERR_CHECK 3'h3
`define ERR_PARITY 3'h4
`define ERR_PREAMBLE 3'h5

// Channel side
`define SCALE_NONE 5'h00
`define OPEN_LOOP_LIMIT 24'h015F90

`endif

// ==== hart_char_unit.v ====
// One HART character transmitter and receiver, 11-bit frame with odd parity
`timescale 1ns/1ps
`include "hart_consts.vh"

module hart_char_unit #(
    parameter [14:0] BIT_CYCLES = `HART_BIT_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Transmit side
    input wire txStart,
    input wire [7:0] txByte,
    output wire txBusy,
    output wire txLine,
    // Receive side
    input wire rxLine,
    input wire rxEnable,
    output reg [7:0] rxByte_r,
    output reg rxValid_r,
    output reg rxParityErr_r
);

// ==========================================
// Transmitter
reg [10:0] txShift_r;
reg [3:0] txBits_r;
reg [14:0] txCnt_r;

assign txBusy = (txBits_r != 4'h0);
assign txLine = txShift_r[0];

always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        txShift_r <= 11'h7FF;
        txBits_r <= 4'h0;
        txCnt_r <= 15'h0000;
    end
    else if (!txBusy)
    begin
        if (txStart)
        begin
            // Stop, odd parity, data LSB first, start
            txShift_r <= {1'b1, ~^txByte, txByte, 1'b0}; // R1
            txBits_r <= 4'hB;
            txCnt_r <= BIT_CYCLES - 15'h0001;
        end
    end
    else if (txCnt_r == 15'h0000)
    begin
        txShift_r <= {1'b1, txShift_r[10:1]};
        txBits_r <= txBits_r - 4'h1;
        txCnt_r <= BIT_CYCLES - 15'h0001;
    end
    else
    begin
        txCnt_r <= txCnt_r - 15'h0001;
    end
end

// ==========================================
// Receiver, samples each bit at its middle
reg [9:0] rxShift_r;
reg [3:0] rxBits_r;
reg [14:0] rxCnt_r;

always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        rxShift_r <= 10'h000;
        rxBits_r <= 4'h0;
        rxCnt_r <= 15'h0000;
        rxByte_r <= 8'h00;
        rxValid_r <= 1'b0;
        rxParityErr_r <= 1'b0;
    end
    else
    begin
        rxValid_r <= 1'b0;
        if (rxBits_r == 4'h0)
        begin
            if (rxEnable && !rxLine)
            begin
                rxBits_r <= 4'hB;
                rxCnt_r <= {1'b0, BIT_CYCLES[14:1]};
            end
        end
        else if (rxCnt_r != 15'h0000)
        begin
            rxCnt_r <= rxCnt_r - 15'h0001;
        end
        else
        begin
            rxCnt_r <= BIT_CYCLES - 15'h0001;
            rxBits_r <= rxBits_r - 4'h1;
            if (rxBits_r == 4'hB)
            begin
                // A glitch that is high again at mid start bit is dropped
                if (rxLine)
                    rxBits_r <= 4'h0;
            end
            else
            begin
                rxShift_r <= {rxLine, rxShift_r[9:1]};
            end
            if (rxBits_r == 4'h1)
            begin
                // rxShift_r now holds data and parity; rxLine is the stop bit
                rxByte_r <= rxShift_r[8:1];
                rxValid_r <= 1'b1;
                rxParityErr_r <= ~(^rxShift_r[9:1]) | ~rxLine; // R1
            end
        end
    end
end

endmodule

// ==== hart_master_framer.v ====
// HART master frame engine for an eight-channel current-input module
// Behaviour
// R1 - Characters run 1200 bps: start, eight data, odd parity, one stop.
// R2 - Request order: preamble, delimiter, address, command, byte count, data, check.
// R3 - Preamble is five to twenty bytes of 0xFF.
// R4 - Address is one byte short-frame, five bytes long-frame.
// R5 - Long delimiters: 0x81 burst, 0x82 master-to-slave, 0x86 slave-to-master.
// R6 - Short delimiters: 0x01 burst, 0x02 master-to-slave, 0x06 slave-to-master.
// R7 - Request byte count equals following data bytes, 0 to 255.
// R8 - Response has two-byte response code plus 0 to 253 data bytes.
// R9 - Check byte appended on transmit, stripped on receive, never host-visible.
// R10 - Check byte is XOR from delimiter to last data; mismatch flags error.
// R11 - One shared modem: only one channel active at a time.
// R12 - Device answers only after a master request addressed to it.
// R13 - Scale code 00 none, 01-29 function number, others treated as 00.
// R14 - Current above 9000.0 flags a possibly disconnected device.
`timescale 1ns/1ps
`include "hart_consts.vh"

module hart_master_framer #(
    parameter [14:0] BIT_CYCLES = `HART_BIT_CYCLES,
    parameter [23:0] RSP_TIMEOUT = `RSP_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Request fields
    input wire reqStart,
    input wire [2:0] reqChannel,
    input wire [4:0] reqPreamble,
    input wire reqLong,
    input wire [39:0] reqAddr,
    input wire [7:0] reqCommand,
    input wire [7:0] reqByteCount,
    // Request data stream
    input wire [7:0] reqData,
    input wire reqDataValid,
    output wire reqDataReady,
    // Response stream and completion
    output reg [7:0] rspByte_r,
    output reg rspValid_r,
    output reg rspIsData_r,
    output reg done_r,
    output reg [2:0] errCode_r,
    output wire busy,
    // Loop channels
    output wire [7:0] chanTx,
    output wire [7:0] chanTxEn,
    input wire [7:0] chanRx,
    // Per-channel scaling and open-loop detection
    input wire [63:0] scaleCode,
    output reg [39:0] scaleSel_r,
    input wire [191:0] currentIn,
    output reg [7:0] openLoop_r
);

localparam [8:0] S_IDLE = 9'h001;
localparam [8:0] S_PRE = 9'h002;
localparam [8:0] S_HDR = 9'h004;
localparam [8:0] S_DATA = 9'h008;
localparam [8:0] S_CHK = 9'h010;
localparam [8:0] S_WAIT = 9'h020;
localparam [8:0] S_RHDR = 9'h040;
localparam [8:0] S_RDATA = 9'h080;
localparam [8:0] S_RCHK = 9'h100;

reg [8:0] state_r;
reg [2:0] chan_r;
reg [4:0] pre_r;
reg long_r;
reg [39:0] addr_r;
reg [7:0] cmd_r;
reg [7:0] bc_r;
reg [7:0] cnt_r;
reg [7:0] chk_r;
reg [7:0] rbc_r;
reg [23:0] timer_r;
reg txGo_r;
reg [7:0] txByte_r;
reg [7:0] sync1_r;
reg [7:0] sync2_r;
reg [7:0] hdrByte;

wire txBusy;
wire txLine;
wire [7:0] rxByte;
wire rxValid;
wire rxParityErr;
wire canSend = !txBusy && !txGo_r;
wire rxListen = (state_r == S_WAIT || state_r == S_RHDR || state_r == S_RDATA
                 || state_r == S_RCHK) && canSend;
wire [7:0] delimTx = long_r ? `DELIM_LONG_M2S : `DELIM_SHORT_M2S; // R5 R6
wire [7:0] delimRx = long_r ? `DELIM_LONG_S2M : `DELIM_SHORT_S2M; // R5 R6
wire [3:0] hdrLen = long_r ? `HDR_LEN_LONG : `HDR_LEN_SHORT; // R4
wire [3:0] rhdrLen = long_r ? `RHDR_LEN_LONG : `RHDR_LEN_SHORT; // R4
wire preOk = (reqPreamble >= `PREAMBLE_MIN) && (reqPreamble <= `PREAMBLE_MAX); // R3

assign busy = (state_r != S_IDLE);
assign reqDataReady = (state_r == S_DATA) && canSend;

// ==========================================
// Channel mux: only the selected loop drives or is heard
genvar g;
generate
    for (g = 0; g < 8; g = g + 1)
    begin : chan
        assign chanTx[g] = (chan_r == g) ? txLine : 1'b1; // R11
        assign chanTxEn[g] = (chan_r == g) && txBusy; // R11

        always @(posedge clock or negedge nrst)
        begin
            if (!nrst)
            begin
                scaleSel_r[5*g+:5] <= `SCALE_NONE;
                openLoop_r[g] <= 1'b0;
            end
            else
            begin
                // Codes are decimal digits in hex nibbles: 16#17 means function 17
                if (scaleCode[8*g+4+:4] <= 4'h2 && scaleCode[8*g+:4] <= 4'h9
                    && scaleCode[8*g+:8] != 8'h00)
                    // Tens digit is at most 2 here, so ten times it fits in five bits
                    scaleSel_r[5*g+:5] <= {scaleCode[8*g+4+:2], 3'b000}
                        + {2'b00, scaleCode[8*g+4+:2], 1'b0}
                        + {1'b0, scaleCode[8*g+:4]}; // R13
                else
                    scaleSel_r[5*g+:5] <= `SCALE_NONE; // R13
                openLoop_r[g] <= (currentIn[24*g+:24] > `OPEN_LOOP_LIMIT); // R14
            end
        end
    end
endgenerate

// Two flops on every loop receive line before the mux
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        sync1_r <= 8'hFF;
        sync2_r <= 8'hFF;
    end
    else
    begin
        sync1_r <= chanRx;
        sync2_r <= sync1_r;
    end
end

hart_char_unit #(
    .BIT_CYCLES(BIT_CYCLES)
) charUnit (
    .clock(clock),
    .nrst(nrst),
    .txStart(txGo_r),
    .txByte(txByte_r),
    .txBusy(txBusy),
    .txLine(txLine),
    .rxLine(sync2_r[chan_r]),
    .rxEnable(rxListen),
    .rxByte_r(rxByte),
    .rxValid_r(rxValid),
    .rxParityErr_r(rxParityErr)
);

// ==========================================
// Header byte selection
always @*
begin
    hdrByte = cmd_r;
    if (cnt_r == 8'h00)
        hdrByte = delimTx;
    else if (cnt_r == {4'h0, hdrLen} - 8'h01)
        hdrByte = bc_r;
    else if (cnt_r == {4'h0, hdrLen} - 8'h02)
        hdrByte = cmd_r;
    else if (long_r)
        hdrByte = addr_r[8*(5-cnt_r[2:0])+:8]; // R4
    else
        hdrByte = addr_r[7:0]; // R4
end

// ==========================================
// Frame sequencer
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        state_r <= S_IDLE;
        chan_r <= 3'h0;
        pre_r <= 5'h00;
        long_r <= 1'b0;
        addr_r <= 40'h0000000000;
        cmd_r <= 8'h00;
        bc_r <= 8'h00;
        cnt_r <= 8'h00;
        chk_r <= 8'h00;
        rbc_r <= 8'h00;
        timer_r <= 24'h000000;
        txGo_r <= 1'b0;
        txByte_r <= 8'h00;
        rspByte_r <= 8'h00;
        rspValid_r <= 1'b0;
        rspIsData_r <= 1'b0;
        done_r <= 1'b0;
        errCode_r <= `ERR_NONE;
    end
    else
    begin
        txGo_r <= 1'b0;
        rspValid_r <= 1'b0;
        done_r <= 1'b0;
        if (rxListen)
            timer_r <= timer_r + 24'h000001;
        case (state_r)
            S_IDLE:
            begin
                // One frame at a time; other channels wait their turn
                if (reqStart && !preOk)
                begin
                    done_r <= 1'b1;
                    errCode_r <= `ERR_PREAMBLE; // R3
                end
                else if (reqStart)
                begin
                    chan_r <= reqChannel; // R11
                    pre_r <= reqPreamble;
                    long_r <= reqLong;
                    addr_r <= reqAddr;
                    cmd_r <= reqCommand;
                    bc_r <= reqByteCount; // R7
                    cnt_r <= 8'h00;
                    state_r <= S_PRE;
                end
            end
            S_PRE:
                if (canSend)
                begin
                    txGo_r <= 1'b1;
                    txByte_r <= `PREAMBLE_BYTE; // R3
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == {3'h0, pre_r} - 8'h01)
                    begin
                        cnt_r <= 8'h00;
                        chk_r <= 8'h00;
                        state_r <= S_HDR; // R2
                    end
                end
            S_HDR:
                if (canSend)
                begin
                    txGo_r <= 1'b1;
                    txByte_r <= hdrByte; // R2
                    chk_r <= chk_r ^ hdrByte; // R10
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == {4'h0, hdrLen} - 8'h01)
                    begin
                        cnt_r <= 8'h00;
                        state_r <= (bc_r == 8'h00) ? S_CHK : S_DATA; // R7
                    end
                end
            S_DATA:
                if (canSend && reqDataValid)
                begin
                    txGo_r <= 1'b1;
                    txByte_r <= reqData;
                    chk_r <= chk_r ^ reqData; // R10
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == bc_r - 8'h01)
                        state_r <= S_CHK; // R7
                end
            S_CHK:
                if (canSend)
                begin
                    txGo_r <= 1'b1;
                    txByte_r <= chk_r; // R9
                    timer_r <= 24'h000000;
                    state_r <= S_WAIT; // R12
                end
            default:
            begin
                if (rxValid && rxParityErr)
                begin
                    done_r <= 1'b1;
                    errCode_r <= `ERR_PARITY; // R1
                    state_r <= S_IDLE;
                end
                else if (rxValid)
                begin
                    cnt_r <= cnt_r + 8'h01;
                    chk_r <= chk_r ^ rxByte; // R10
                    if (state_r != S_RCHK && state_r != S_WAIT)
                    begin
                        rspByte_r <= rxByte;
                        rspValid_r <= 1'b1;
                        rspIsData_r <= (state_r == S_RDATA); // R8
                    end
                    if (state_r == S_WAIT && rxByte != `PREAMBLE_BYTE)
                    begin
                        cnt_r <= 8'h00;
                        chk_r <= rxByte;
                        if (rxByte == delimRx)
                            state_r <= S_RHDR;
                        else
                        begin
                            done_r <= 1'b1;
                            errCode_r <= `ERR_DELIM;
                            state_r <= S_IDLE;
                        end
                    end
                    else if (state_r == S_RHDR && cnt_r == {4'h0, rhdrLen} - 8'h01)
                    begin
                        // Byte count covers response code plus data
                        rbc_r <= rxByte; // R8
                        cnt_r <= 8'h00;
                        state_r <= (rxByte == 8'h00) ? S_RCHK : S_RDATA;
                    end
                    else if (state_r == S_RDATA && cnt_r == rbc_r - 8'h01)
                        state_r <= S_RCHK;
                    else if (state_r == S_RCHK)
                    begin
                        // Check byte is consumed here and never forwarded
                        done_r <= 1'b1;
                        errCode_r <= (chk_r == rxByte) ? `ERR_NONE : `ERR_CHECK; // R9 R10
                        state_r <= S_IDLE;
                    end
                end
                else if (timer_r == RSP_TIMEOUT)
                begin
                    done_r <= 1'b1;
                    errCode_r <= `ERR_TIMEOUT;
                    state_r <= S_IDLE;
                end
            end
        endcase
    end
end

endmodule

// ==== hart_field_dev.sv ====
// Behavioural HART field device on one loop channel
`timescale 1ns/1ps
module hart_field_dev #(
    parameter int BITC = 16
) (
    // Loop lines
    input wire logic clock,
    input wire logic txLine,
    output logic rxLine,
    // Scenario control: 0 good, 1 bad check, 2 silent, 3 burst delimiter, 4 bad parity
    input wire logic [2:0] mode,
    input wire logic [7:0] nData
);
    // ====================
    // Listen, then answer
    logic [8:0] got[$];
    logic [8:0] q[$];
    int nPre = 0;
    int parBad = 0;

    task automatic waitBits(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic getChar(output logic [7:0] b);
        logic [8:0] c;
        while (txLine !== 1'b0)
            @(posedge clock);
        waitBits(BITC / 2);
        for (int i = 0; i < 9; i++)
        begin
            waitBits(BITC);
            c[i] = txLine;
        end
        waitBits(BITC);
        if (^c !== 1'b1 || txLine !== 1'b1)
            parBad++;
        b = c[7:0];
    endtask

    task automatic putChar(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        f = {1'b1, (~^b) ^ bad, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxLine <= f[i];
            waitBits(BITC);
        end
    endtask

    initial
    begin
        logic [7:0] b;
        logic [8:0] x;
        int na;
        rxLine = 1'b1;
        forever
        begin
            nPre = 0;
            getChar(b);
            while (b == 8'hFF)
            begin
                nPre++;
                getChar(b);
            end
            got = {{1'b0, b}};
            na = b[7] ? 5 : 1;
            for (int k = 0; k < na + 2; k++)
            begin
                getChar(b);
                got.push_back({1'b0, b});
            end
            for (int k = 0; k <= got[na + 2]; k++)
            begin
                getChar(b);
                got.push_back({1'b0, b});
            end
            // Answer only once a whole request has arrived
            if (mode != 3'h2)
            begin
                waitBits(BITC * 2);
                q = got[0:na + 1];
                q[0] = mode == 3'h3 ? q[0] ^ 9'h003 : q[0] | 9'h004;
                q.push_back(nData + 9'h002);
                q.push_back(9'h000);
                q.push_back(9'h040);
                for (int k = 0; k < nData; k++)
                    q.push_back(9'h0A0 + k[8:0]);
                x = 9'h000;
                foreach (q[j])
                    x ^= q[j];
                q.push_back(mode == 3'h1 ? ~x : x);
                repeat (5) putChar(8'hFF, 1'b0);
                // Parity is spoilt on the last byte only, so the frame still ends on time
                foreach (q[j])
                    putChar(q[j][7:0], mode == 3'h4 && j == q.size() - 1);
            end
        end
    end
endmodule

// ==== hart_master_framer_chk.sv ====
// Port-level assertions for the HART master frame engine
`timescale 1ns/1ps
module hart_master_framer_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Request and results
    input wire logic reqStart,
    input wire logic [4:0] reqPreamble,
    input wire logic reqDataReady,
    input wire logic rspValid_r,
    input wire logic done_r,
    input wire logic [2:0] errCode_r,
    input wire logic busy,
    // Channels
    input wire logic [7:0] chanTx,
    input wire logic [7:0] chanTxEn,
    input wire logic [191:0] currentIn,
    input wire logic [7:0] openLoop_r
);
    // ====================
    // Assertions
    function automatic logic [7:0] openMap(input logic [191:0] c);
        for (int i = 0; i < 8; i++)
            openMap[i] = c[24 * i +: 24] > 24'h015F90;
    endfunction

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_one_channel: assert property ($onehot0(chanTxEn))
        else $error("two loop channels driven");
    a_idle_high: assert property (&(chanTx | chanTxEn))
        else $error("loop line low outside a character");
    a_start_low: assert property ($rose(|chanTxEn) |-> (chanTx & chanTxEn) == 8'h00)
        else $error("character does not open with a low bit");
    a_pre_refused: assert property (reqStart && !busy && (reqPreamble < 5'h05 ||
        reqPreamble > 5'h14) |=> done_r && errCode_r == 3'h5 && !busy)
        else $error("bad preamble count not refused");
    a_start_busy: assert property (reqStart && !busy && reqPreamble >= 5'h05 &&
        reqPreamble <= 5'h14 |=> busy [*2])
        else $error("request not taken");
    a_done_pulse: assert property (done_r |=> !done_r)
        else $error("done longer than one cycle");
    a_rx_quiet: assert property (!busy && !$past(busy) && !$past(busy, 2) |-> !rspValid_r)
        else $error("response byte outside a request");
    a_ready_busy: assert property (reqDataReady |-> busy)
        else $error("data taken while idle");
    a_open_loop: assert property (1 |=> openLoop_r == openMap($past(currentIn)))
        else $error("open loop flags wrong");
endmodule

bind hart_master_framer hart_master_framer_chk hart_master_framer_chk_i (
    .clock(clock), .nrst(nrst), .reqStart(reqStart), .reqPreamble(reqPreamble),
    .reqDataReady(reqDataReady), .rspValid_r(rspValid_r), .done_r(done_r),
    .errCode_r(errCode_r), .busy(busy), .chanTx(chanTx), .chanTxEn(chanTxEn),
    .currentIn(currentIn), .openLoop_r(openLoop_r)
);

// ==== hart_master_framer_tb_top.sv ====
// Self-checking bench for the HART master frame engine
`timescale 1ns/1ps
module hart_master_framer_tb_top;
    // ====================
    // Design, field devices and helpers
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic reqStart = 1'b0;
    logic [2:0] reqChannel = 3'h0;
    logic [4:0] reqPreamble = 5'h05;
    logic reqLong = 1'b0;
    logic [7:0] reqByteCount = 8'h00;
    logic [7:0] reqData = 8'h00;
    logic reqDataValid = 1'b0;
    logic [63:0] scaleCode = 64'h0;
    logic [191:0] currentIn = 192'h0;
    logic [2:0] mode = 3'h0;
    logic [39:0] reqAddr = 40'h0000000000;
    logic [7:0] reqCommand = 8'h3C;
    logic [7:0] nData = 8'h00;
    wire [7:0] chanRx, chanTx, chanTxEn, rspByte_r, openLoop_r;
    wire [39:0] scaleSel_r;
    wire [2:0] errCode_r;
    wire reqDataReady, rspValid_r, rspIsData_r, done_r, busy;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [8:0] rq[$];

    always #25 clock = ~clock;

    hart_master_framer #(.BIT_CYCLES(15'h0010), .RSP_TIMEOUT(24'h001B80)) hart_master_framer_i (
        .clock(clock), .nrst(nrst), .reqStart(reqStart), .reqChannel(reqChannel),
        .reqPreamble(reqPreamble), .reqLong(reqLong), .reqAddr(reqAddr),
        .reqCommand(reqCommand), .reqByteCount(reqByteCount), .reqData(reqData),
        .reqDataValid(reqDataValid), .reqDataReady(reqDataReady), .rspByte_r(rspByte_r),
        .rspValid_r(rspValid_r), .rspIsData_r(rspIsData_r), .done_r(done_r),
        .errCode_r(errCode_r), .busy(busy), .chanTx(chanTx), .chanTxEn(chanTxEn),
        .chanRx(chanRx), .scaleCode(scaleCode), .scaleSel_r(scaleSel_r),
        .currentIn(currentIn), .openLoop_r(openLoop_r));

    for (genvar g = 0; g < 8; g++)
    begin : dv
        hart_field_dev #(.BITC(16)) hart_field_dev_i (.clock(clock), .txLine(chanTx[g]),
            .rxLine(chanRx[g]), .mode(mode), .nData(nData));
    end

    // Sampled mid-cycle, where the registered pulse has settled
    always @(negedge clock)
        if (rspValid_r === 1'b1)
            rq.push_back({rspIsData_r, rspByte_r});

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t ns: got 0x%0h, expected 0x%0h", $time, got, exp);
        end
    endtask

    task automatic cmpQ(input logic [8:0] got[$], input logic [8:0] exp[$]);
        chk(got.size(), exp.size());
        foreach (exp[i])
            chk(got[i], exp[i]);
    endtask

    // Host stalls 300 cycles after each data byte so the engine must wait
    task automatic sendReq(input logic [2:0] ch, input logic [4:0] pre, input logic lng,
        input logic [7:0] bc, output int w);
        int k;
        int gap;
        logic took;
        k = 0;
        gap = 0;
        w = 0;
        @(posedge clock);
        #1;
        rq = {};
        reqChannel = ch;
        reqPreamble = pre;
        reqLong = lng;
        reqByteCount = bc;
        reqStart = 1'b1;
        @(posedge clock);
        #1;
        reqStart = 1'b0;
        while (done_r !== 1'b1 && w < 20000)
        begin
            reqDataValid = k < bc && w > gap;
            reqData = 8'h50 + k[7:0];
            took = reqDataValid && reqDataReady === 1'b1;
            @(posedge clock);
            if (took)
            begin
                k++;
                gap = w + 300;
            end
            #1;
            w++;
        end
        reqDataValid = 1'b0;
        chk(done_r, 1'b1);
    endtask

    // ====================
    // Scenarios
    task automatic t_scale();
        scaleCode = 64'h15990A1730290100;
        currentIn = {24'hFFFFFF, 120'h0, 24'h015F91, 24'h015F90};
        repeat (2) @(posedge clock);
        #1;
        chk(scaleSel_r, {5'h0F, 5'h00, 5'h00, 5'h11, 5'h00, 5'h1D, 5'h01, 5'h00});
        chk(openLoop_r, 8'h82);
    endtask

    task automatic t_pre();
        int w;
        sendReq(3'h1, 5'h04, 1'b0, 8'h00, w);
        chk(w, 0);
        chk(errCode_r, 3'h5);
        sendReq(3'h1, 5'h15, 1'b0, 8'h00, w);
        chk(errCode_r, 3'h5);
        chk(busy, 1'b0);
    endtask

    task automatic t_short();
        int w;
        mode = 3'h0;
        nData = 8'h01;
        // Upper address bytes must never reach a short frame
        reqAddr = 40'hAAAAAAAA55;
        sendReq(3'h3, 5'h05, 1'b0, 8'h00, w);
        chk(errCode_r, 3'h0);
        chk(dv[3].hart_field_dev_i.nPre, 5);
        cmpQ(dv[3].hart_field_dev_i.got, '{9'h002, 9'h055, 9'h03C, 9'h000, 9'h06B});
        cmpQ(rq, '{9'h055, 9'h03C, 9'h003, 9'h100, 9'h140, 9'h1A0});
    endtask

    task automatic t_long();
        int w;
        nData = 8'h00;
        reqAddr = 40'h1122334455;
        sendReq(3'h6, 5'h14, 1'b1, 8'h02, w);
        chk(errCode_r, 3'h0);
        chk(dv[6].hart_field_dev_i.nPre, 20);
        chk(dv[6].hart_field_dev_i.parBad, 0);
        cmpQ(dv[6].hart_field_dev_i.got, '{9'h082, 9'h011, 9'h022, 9'h033, 9'h044,
            9'h055, 9'h03C, 9'h002, 9'h050, 9'h051, 9'h0AC});
        cmpQ(rq, '{9'h011, 9'h022, 9'h033, 9'h044, 9'h055, 9'h03C, 9'h002,
            9'h100, 9'h140});
    endtask

    task automatic t_fault();
        int w;
        logic [2:0] modes[4];
        logic [2:0] expErr[4];
        // Burst delimiter goes last: the device keeps talking after the early stop
        modes = '{3'h1, 3'h2, 3'h4, 3'h3};
        expErr = '{3'h3, 3'h1, 3'h4, 3'h2};
        for (int m = 0; m < 4; m++)
        begin
            mode = modes[m];
            sendReq(3'h0, 5'h05, modes[m] == 3'h3, 8'h00, w);
            chk(errCode_r, expErr[m]);
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        #1;
        nrst = 1'b1;
        t_scale();
        t_pre();
        t_short();
        t_long();
        t_fault();
        end_of_test();
    end

    initial
    begin
        #4000000;
        n_mismatch++;
        end_of_test();
    end
endmodule
